// ### hw/iith_hub.sv
// trigger inputs, countdown timers and output routing behind wishbone
// How it works
// [R1] twelve trigger inputs, each separately configured
// [R2] per input: rising, falling, high or low
// [R3] driver holds each level one microsecond minimum
// [R4] any pulse of one microsecond is caught
// [R5] every input resets to falling edge mode
// [R6] host interrupt only when armed and enabled
// [R7] arm and enable bits set/cleared individually
// [R8] software can inject a request per input
// [R9] one host interrupt line per input
// [R10] any input may drive a chain line
// [R11] eight timers, each with 32-bit count
// [R12] interval is count times chosen resolution
// [R13] periodic timers reload original value at zero
// [R14] load, modify, read count/resolution, start, stop
// [R15] timer expiry feeds host, chain, outputs
// [R16] any timer may drive a chain line
// [R17] twelve external output lines
// [R18] each output picks one source, pulse default
// [R19] armed requests latch; disarm clears and ignores
// [R20] disabled but armed input still holds requests
// [R21] host clears pending before next delivery
// [R22] all inputs reset disarmed and disabled
// [R23] inputs pass two-stage synchroniser first
// [R24] one-shot expires once then stops
// [R25] level mode re-requests while level persists
`timescale 1ns/1ps
`default_nettype none
module iith_hub
  import iith_pkg::*;
(
  input wire logic clk_i,  // board clock, 125 MHz
  input wire logic rst_i,  // sync reset, high
  input wire logic wb_cyc_i,  // bus cycle
  input wire logic wb_stb_i,  // strobe
  input wire logic wb_we_i,  // write
  input wire logic [7:0] wb_adr_i,  // byte address
  input wire logic [3:0] wb_sel_i,  // byte lanes
  input wire logic [31:0] wb_dat_i,  // write data
  output logic [31:0] wb_dat_o,  // read data
  output logic wb_ack_o,  // acknowledge
  input wire logic [NUM_IN-1:0] trig_i,  // async trigger pins
  output logic [NUM_IN-1:0] host_irq_o,  // input interrupts
  output logic [NUM_TMR-1:0] tmr_irq_o,  // timer interrupts
  output logic [NUM_CHAIN-1:0] chain_shared_interrupt_o,  // chain lines
  output logic [NUM_OUT-1:0] ext_out_o  // external output lines
);
  iith_bus_req_t req;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [31:0] wmask;
  logic bus_go;
  logic wr_go;
  logic rd_go;
  logic [31:0] wr_bits;
  logic [31:0] rd_val;

  logic [NUM_IN-1:0] sync1_ff;
  logic [NUM_IN-1:0] sync2_ff;
  logic [NUM_IN-1:0] prev_ff;
  logic [NUM_IN-1:0] hit;
  logic [NUM_IN-1:0] inject;
  logic [NUM_IN-1:0] new_req;

  logic [MODE_W*NUM_IN-1:0] mode_ff;
  logic [NUM_IN-1:0] arm_ff;
  logic [NUM_IN-1:0] en_ff;
  logic [NUM_IN-1:0] pend_ff;
  logic [NUM_IN-1:0] nxt_arm_ff;
  logic [NUM_IN-1:0] pend_clr;
  logic [NUM_IN-1:0] host_irq_ff;

  logic [NUM_CHAIN*SRC_W-1:0] chain_sel_ff;
  logic [NUM_OUT*SRC_W-1:0] out_sel_ff;
  logic [NUM_OUT-1:0] pulse_ff;
  logic [NUM_CHAIN-1:0] chain_ff;
  logic [NUM_OUT-1:0] ext_out_ff;
  logic [31:0] src_vec;

  logic [7:0] us_cnt_ff;
  logic [NUM_RES-1:0] tick_ff;
  logic [3:0] dec_cnt_ff [NUM_RES-1];

  iith_tmr_cfg_t cfg_ff [NUM_TMR];
  logic [NUM_TMR-1:0] tmr_pend_ff;
  logic [NUM_TMR-1:0] tmr_exp;
  logic [NUM_TMR-1:0] tmr_run;
  logic [CNT_W-1:0] tmr_cnt [NUM_TMR];
  logic [CNT_W-1:0] tmr_rel [NUM_TMR];
  logic tmr_area;
  logic [2:0] tmr_idx;
  logic [3:0] tmr_reg;

  // merge written byte lanes into an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // pick one source for a line; code zero means its own pulse bit
  function automatic logic pick(input logic [SRC_W-1:0] s, input logic own_pulse,
                                input logic [31:0] v);
    pick = (s == SRC_PULSE) ? own_pulse : v[s];
  endfunction

  // bus request as taken from the pins
  assign req = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};
  assign wmask = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};
  assign bus_go = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr_go = bus_go && req.we;
  assign rd_go = bus_go && !req.we;
  assign wr_bits = req.dat & wmask;
  assign tmr_area = req.adr[TMR_SEL_BIT];
  assign tmr_idx = req.adr[6:4];
  assign tmr_reg = req.adr[3:0];

  // single-cycle ack; dropped the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_go;
    end
  end

  // read data captured with the ack, held until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= '0;
    end else if (rd_go) begin
      dat_ff <= rd_val;
    end
  end

  // two flops before anything looks at a pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= trig_i;  // [R23]
      sync2_ff <= sync1_ff;  // [R23]
      prev_ff <= sync2_ff;
    end
  end

  // recognition per mode; level modes request every cycle
  always_comb begin
    hit = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      unique case (iith_trig_t'(mode_ff[MODE_W*i +: MODE_W]))  // [R2]
        TRIG_RISING: hit[i] = sync2_ff[i] && !prev_ff[i];  // [R4]
        TRIG_FALLING: hit[i] = !sync2_ff[i] && prev_ff[i];  // [R4]
        TRIG_HIGH: hit[i] = sync2_ff[i];  // [R25]
        TRIG_LOW: hit[i] = !sync2_ff[i];  // [R25]
      endcase
    end
  end

  // software injection enters as an ordinary request
  assign inject = (wr_go && req.adr == OFS_INJECT) ? wr_bits[NUM_IN-1:0] : '0;  // [R8]
  assign new_req = hit | inject;  // [R8]
  assign pend_clr = (wr_go && req.adr == OFS_PEND_CLR) ? wr_bits[NUM_IN-1:0] : '0;

  // mode per input, falling edge after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= MODE_RST;  // [R5]
    end else if (wr_go && req.adr == OFS_MODE) begin
      mode_ff <= (MODE_W*NUM_IN)'(merge(32'(mode_ff), req.dat, wmask));  // [R1]
    end
  end

  // arm: separate set and clear words so inputs do not disturb each other
  always_comb begin
    nxt_arm_ff = arm_ff;
    if (wr_go && req.adr == OFS_ARM_SET) begin
      nxt_arm_ff = arm_ff | wr_bits[NUM_IN-1:0];  // [R7]
    end else if (wr_go && req.adr == OFS_ARM_CLR) begin
      nxt_arm_ff = arm_ff & ~wr_bits[NUM_IN-1:0];  // [R7]
    end
  end

  // arm and enable both start cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_ff <= '0;  // [R22]
      en_ff <= '0;  // [R22]
    end else begin
      arm_ff <= nxt_arm_ff;
      if (wr_go && req.adr == OFS_EN_SET) begin
        en_ff <= en_ff | wr_bits[NUM_IN-1:0];  // [R7]
      end else if (wr_go && req.adr == OFS_EN_CLR) begin
        en_ff <= en_ff & ~wr_bits[NUM_IN-1:0];  // [R7]
      end
    end
  end

  // pending: a request in the clearing cycle wins, disarm wipes that input's pending bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= ((pend_ff & ~pend_clr) | (new_req & arm_ff)) & nxt_arm_ff;  // [R19] [R20] [R21]
    end
  end

  // delivery gated by enable; held pending goes out once enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_irq_ff <= '0;
    end else begin
      host_irq_ff <= pend_ff & en_ff & arm_ff;  // [R6] [R9] [R20]
    end
  end

  // 1 us base tick from the board clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      us_cnt_ff <= '0;
      tick_ff[0] <= 1'b0;
    end else begin
      tick_ff[0] <= (us_cnt_ff == 8'(TICK_CYC - 1));
      us_cnt_ff <= (us_cnt_ff == 8'(TICK_CYC - 1)) ? '0 : us_cnt_ff + 8'h01;
    end
  end

  // decade chain for 10 us, 100 us and 1 ms ticks
  for (genvar d = 1; d < NUM_RES; d++) begin : g_dec
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        dec_cnt_ff[d-1] <= '0;
        tick_ff[d] <= 1'b0;
      end else begin
        tick_ff[d] <= tick_ff[d-1] && (dec_cnt_ff[d-1] == 4'(DECADE - 1));
        if (tick_ff[d-1]) begin
          dec_cnt_ff[d-1] <= (dec_cnt_ff[d-1] == 4'(DECADE - 1)) ? '0 : dec_cnt_ff[d-1] + 4'h1;
        end
      end
    end
  end

  // eight timers; resolution chooses which tick drives each
  for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
    logic hit_t;
    assign hit_t = wr_go && tmr_area && (tmr_idx == 3'(t));

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cfg_ff[t] <= '0;
      end else if (hit_t && tmr_reg == TMR_OFS_CTRL && req.sel[0]) begin
        cfg_ff[t].res <= req.dat[CTRL_RES_LSB +: RES_W];  // [R12]
        cfg_ff[t].periodic <= req.dat[CTRL_PER_BIT];  // [R13]
      end
    end

    iith_timer #(
      .W(CNT_W)
    ) u_tmr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick_ff[cfg_ff[t].res]),  // [R12]
      .load_i(hit_t && tmr_reg == TMR_OFS_LOAD),
      .mod_i(hit_t && tmr_reg == TMR_OFS_MOD),
      .val_i(merge(tmr_cnt[t], req.dat, wmask)),
      .periodic_i(cfg_ff[t].periodic),
      .start_i(hit_t && tmr_reg == TMR_OFS_CTRL && req.sel[0] && req.dat[CTRL_RUN_BIT]),
      .stop_i(hit_t && tmr_reg == TMR_OFS_CTRL && req.sel[0] && !req.dat[CTRL_RUN_BIT]),
      .count_o(tmr_cnt[t]),
      .reload_o(tmr_rel[t]),
      .running_o(tmr_run[t]),
      .expire_o(tmr_exp[t])
    );
  end

  // timer expiry sticky for the host; a new expiry beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_pend_ff <= '0;
    end else if (wr_go && req.adr == OFS_TMR_PEND) begin
      tmr_pend_ff <= (tmr_pend_ff & ~wr_bits[NUM_TMR-1:0]) | tmr_exp;  // [R15]
    end else begin
      tmr_pend_ff <= tmr_pend_ff | tmr_exp;  // [R15] [R11]
    end
  end

  // routing sources: synced raw input bypasses local arm/enable
  assign src_vec = 32'({tmr_exp, sync2_ff, 1'b0});  // [R10] [R16]

  // routing selects and software pulse bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain_sel_ff <= CHAIN_SEL_RST;
      out_sel_ff <= OUT_SEL_RST;
      pulse_ff <= '0;
    end else if (wr_go) begin
      if (req.adr == OFS_CHAIN_SEL) begin
        chain_sel_ff <= (NUM_CHAIN*SRC_W)'(merge(32'(chain_sel_ff), req.dat, wmask));
      end
      if (req.adr == OFS_OUT_SEL_LO) begin
        out_sel_ff[0 +: OUT_PER_REG*SRC_W] <=
          (OUT_PER_REG*SRC_W)'(merge(32'(out_sel_ff[0 +: OUT_PER_REG*SRC_W]), req.dat, wmask));
      end
      if (req.adr == OFS_OUT_SEL_HI) begin
        out_sel_ff[OUT_PER_REG*SRC_W +: OUT_PER_REG*SRC_W] <=
          (OUT_PER_REG*SRC_W)'(merge(32'(out_sel_ff[OUT_PER_REG*SRC_W +: OUT_PER_REG*SRC_W]),
                req.dat, wmask));
      end
      if (req.adr == OFS_PULSE) begin
        pulse_ff <= NUM_OUT'(merge(32'(pulse_ff), req.dat, wmask));  // [R18]
      end
    end
  end

  // chain lines and output lines, registered so pins never glitch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain_ff <= '0;
      ext_out_ff <= '0;
    end else begin
      for (int c = 0; c < NUM_CHAIN; c++) begin
        chain_ff[c] <= pick(chain_sel_ff[SRC_W*c +: SRC_W], pulse_ff[c], src_vec);  // [R10] [R16]
      end
      for (int o = 0; o < NUM_OUT; o++) begin
        ext_out_ff[o] <= pick(out_sel_ff[SRC_W*o +: SRC_W], pulse_ff[o], src_vec);  // [R17] [R18]
      end
    end
  end

  // register read mux; unmapped words read as zero
  always_comb begin
    rd_val = '0;
    if (tmr_area) begin
      unique case (tmr_reg)
        TMR_OFS_LOAD: rd_val = tmr_cnt[tmr_idx];  // [R14]
        TMR_OFS_MOD: rd_val = tmr_rel[tmr_idx];
        TMR_OFS_CTRL: begin
          rd_val[CTRL_RES_LSB +: RES_W] = cfg_ff[tmr_idx].res;  // [R14]
          rd_val[CTRL_PER_BIT] = cfg_ff[tmr_idx].periodic;
          rd_val[CTRL_RUN_BIT] = tmr_run[tmr_idx];
        end
        default: rd_val = '0;
      endcase
    end else begin
      unique case (req.adr)
        OFS_MODE: rd_val = 32'(mode_ff);
        OFS_ARM_SET: rd_val = 32'(arm_ff);
        OFS_EN_SET: rd_val = 32'(en_ff);
        OFS_INJECT: rd_val = 32'(pend_ff);
        OFS_PEND_CLR: rd_val = 32'(host_irq_ff);
        OFS_CHAIN_SEL: rd_val = 32'(chain_sel_ff);
        OFS_OUT_SEL_LO: rd_val = 32'(out_sel_ff[0 +: OUT_PER_REG*SRC_W]);
        OFS_OUT_SEL_HI: rd_val = 32'(out_sel_ff[OUT_PER_REG*SRC_W +: OUT_PER_REG*SRC_W]);
        OFS_PULSE: rd_val = 32'(pulse_ff);
        OFS_TMR_PEND: rd_val = 32'(tmr_pend_ff);
        default: rd_val = '0;
      endcase
    end
  end

  // every output straight from a flop
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign host_irq_o = host_irq_ff;
  assign tmr_irq_o = tmr_pend_ff;
  assign chain_shared_interrupt_o = chain_ff;
  assign ext_out_o = ext_out_ff;
endmodule
`default_nettype wire

// ### hw/iith_pkg.sv
// shared constants and types for the interrupt input and timer hub
package iith_pkg;
  // sizes of the block
  localparam int NUM_IN = 12;
  localparam int NUM_TMR = 8;
  localparam int NUM_OUT = 12;
  localparam int NUM_CHAIN = 4;
  localparam int CNT_W = 32;
  localparam int SRC_W = 5;
  localparam int RES_W = 2;
  localparam int NUM_RES = 4;
  localparam int OUT_PER_REG = 6;
  // timing: base tick of 1 us, then decades
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = CLK_MHZ * TICK_US;
  localparam int DECADE = 10;
  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_ARM_SET = 8'h04;
  localparam logic [7:0] OFS_ARM_CLR = 8'h08;
  localparam logic [7:0] OFS_EN_SET = 8'h0C;
  localparam logic [7:0] OFS_EN_CLR = 8'h10;
  localparam logic [7:0] OFS_INJECT = 8'h14;
  localparam logic [7:0] OFS_PEND_CLR = 8'h18;
  localparam logic [7:0] OFS_CHAIN_SEL = 8'h1C;
  localparam logic [7:0] OFS_OUT_SEL_LO = 8'h20;
  localparam logic [7:0] OFS_OUT_SEL_HI = 8'h24;
  localparam logic [7:0] OFS_PULSE = 8'h28;
  localparam logic [7:0] OFS_TMR_PEND = 8'h2C;
  // timer n sits at 0x80 + 0x10*n, selected by address bit 7
  localparam int TMR_SEL_BIT = 7;
  localparam logic [3:0] TMR_OFS_LOAD = 4'h0;
  localparam logic [3:0] TMR_OFS_MOD = 4'h4;
  localparam logic [3:0] TMR_OFS_CTRL = 4'h8;
  // timer control fields
  localparam int CTRL_RES_LSB = 0;
  localparam int CTRL_PER_BIT = 2;
  localparam int CTRL_RUN_BIT = 3;
  // trigger modes, two bits per input
  typedef enum logic [1:0] {TRIG_RISING, TRIG_FALLING, TRIG_HIGH, TRIG_LOW} iith_trig_t;
  localparam int MODE_W = 2;
  localparam logic [MODE_W*NUM_IN-1:0] MODE_RST = {NUM_IN{TRIG_FALLING}};
  // source select codes for chain lines and output lines
  localparam logic [SRC_W-1:0] SRC_PULSE = 5'h00;
  localparam logic [SRC_W-1:0] SRC_IN0 = 5'h01;
  localparam logic [SRC_W-1:0] SRC_TMR0 = 5'h0D;
  localparam logic [SRC_W-1:0] SRC_NONE = 5'h1F;
  localparam logic [NUM_CHAIN*SRC_W-1:0] CHAIN_SEL_RST = {NUM_CHAIN{SRC_NONE}};
  localparam logic [NUM_OUT*SRC_W-1:0] OUT_SEL_RST = '0;
  // per-timer configuration
  typedef struct packed {
    logic [RES_W-1:0] res;
    logic periodic;
  } iith_tmr_cfg_t;
  // one bus request as taken from the wishbone pins
  typedef struct packed {
    logic [7:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } iith_bus_req_t;
endpackage

// ### hw/iith_timer.sv
// one countdown timer with reload, one-shot and periodic modes
`timescale 1ns/1ps
`default_nettype none
module iith_timer
  import iith_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic clk_i,  // board clock
  input wire logic rst_i,  // sync reset, high
  input wire logic tick_i,  // one pulse per resolution step
  input wire logic load_i,  // load count and reload value
  input wire logic mod_i,  // change current count only
  input wire logic [W-1:0] val_i,  // value for load or modify
  input wire logic periodic_i,  // reload at zero
  input wire logic start_i,  // begin counting
  input wire logic stop_i,  // halt counting
  output logic [W-1:0] count_o,  // current count
  output logic [W-1:0] reload_o,  // value given at last load
  output logic running_o,  // counting
  output logic expire_o  // one-cycle expiry pulse
);
  logic [W-1:0] count_ff;
  logic [W-1:0] reload_ff;
  logic run_ff;
  logic expire_ff;
  logic at_end;

  // a count of one or zero ends on this tick
  assign at_end = (count_ff <= W'(1));

  // reload value only changes on a full load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reload_ff <= '0;
    end else if (load_i) begin
      reload_ff <= val_i;  // [R14]
    end
  end

  // count down once per tick; interval is count times resolution
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= '0;
    end else if (load_i || mod_i) begin
      count_ff <= val_i;  // [R14]
    end else if (run_ff && tick_i) begin
      if (at_end) begin
        count_ff <= periodic_i ? reload_ff : '0;  // [R13]
      end else begin
        count_ff <= count_ff - W'(1);  // [R12]
      end
    end
  end

  // stop beats start; one-shot drops out after expiry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_ff <= 1'b0;
    end else if (stop_i) begin
      run_ff <= 1'b0;  // [R14]
    end else if (start_i) begin
      run_ff <= 1'b1;  // [R14]
    end else if (run_ff && tick_i && at_end && !periodic_i) begin
      run_ff <= 1'b0;  // [R24]
    end
  end

  // expiry strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      expire_ff <= 1'b0;
    end else begin
      expire_ff <= run_ff && tick_i && at_end;  // [R24]
    end
  end

  assign count_o = count_ff;
  assign reload_o = reload_ff;
  assign running_o = run_ff;
  assign expire_o = expire_ff;
endmodule
`default_nettype wire

// ### verification/iith_hub_sva.sv
// port-level assertions for the interrupt input and timer hub
`timescale 1ns/1ps
`default_nettype none
module iith_hub_sva
  import iith_pkg::*;
(
  input wire logic clk_i,  // board clock
  input wire logic rst_i,  // sync reset
  input wire logic wb_cyc_i,  // bus cycle
  input wire logic wb_stb_i,  // strobe
  input wire logic wb_we_i,  // write
  input wire logic [7:0] wb_adr_i,  // byte address
  input wire logic [3:0] wb_sel_i,  // byte lanes
  input wire logic [31:0] wb_dat_i,  // write data
  input wire logic [31:0] wb_dat_o,  // read data
  input wire logic wb_ack_o,  // acknowledge
  input wire logic [NUM_IN-1:0] trig_i,  // trigger pins
  input wire logic [NUM_IN-1:0] host_irq_o,  // input interrupts
  input wire logic [NUM_TMR-1:0] tmr_irq_o,  // timer interrupts
  input wire logic [NUM_CHAIN-1:0] chain_shared_interrupt_o,  // chain lines
  input wire logic [NUM_OUT-1:0] ext_out_o  // output lines
);
  logic take;
  logic clr_t;
  logic [NUM_IN-1:0] wmask;
  logic [NUM_IN-1:0] arm_ff;
  logic [NUM_IN-1:0] en_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request is taken on the edge where ack is still low
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign clr_t = take && wb_we_i && wb_adr_i == OFS_TMR_PEND;
  assign wmask = wb_dat_i[NUM_IN-1:0] & {{4{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // shadow of the arm bits, to judge gating and read-back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_ff <= '0;
    end else if (take && wb_we_i && wb_adr_i == OFS_ARM_SET) begin
      arm_ff <= arm_ff | wmask;
    end else if (take && wb_we_i && wb_adr_i == OFS_ARM_CLR) begin
      arm_ff <= arm_ff & ~wmask;
    end
  end
  // shadow of the enable bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff <= '0;
    end else if (take && wb_we_i && wb_adr_i == OFS_EN_SET) begin
      en_ff <= en_ff | wmask;
    end else if (take && wb_we_i && wb_adr_i == OFS_EN_CLR) begin
      en_ff <= en_ff & ~wmask;
    end
  end
  property p_ack_resp; take |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_rst_out;
    $fell(rst_i) |-> host_irq_o == '0 && tmr_irq_o == '0
      && chain_shared_interrupt_o == '0 && ext_out_o == '0;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle");
  property p_irq_gate; (host_irq_o & ~$past(arm_ff & en_ff)) == '0; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");
  property p_arm_read;
    wb_ack_o && $past(take && !wb_we_i && wb_adr_i == OFS_ARM_SET)
      |-> wb_dat_o == 32'($past(arm_ff));
  endproperty
  a_arm_read: assert property (p_arm_read) else $error("arm read wrong");
  property p_en_read;
    wb_ack_o && $past(take && !wb_we_i && wb_adr_i == OFS_EN_SET)
      |-> wb_dat_o == 32'($past(en_ff));
  endproperty
  a_en_read: assert property (p_en_read) else $error("enable read wrong");
  property p_tmr_sticky;
    |($past(tmr_irq_o) & ~tmr_irq_o) |-> $past(clr_t, 1) || $past(clr_t, 2) || $past(rst_i);
  endproperty
  a_tmr_sticky: assert property (p_tmr_sticky) else $error("timer irq lost");
  // main scenarios reached
  c_host: cover property ($rose(host_irq_o[0]));
  c_tmr: cover property ($rose(tmr_irq_o[7]));
  c_chain: cover property ($rose(chain_shared_interrupt_o[0]));
  c_out: cover property ($rose(ext_out_o[2]));
endmodule
bind iith_hub iith_hub_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_i(trig_i),
  .host_irq_o(host_irq_o), .tmr_irq_o(tmr_irq_o),
  .chain_shared_interrupt_o(chain_shared_interrupt_o), .ext_out_o(ext_out_o));
`default_nettype wire

// ### verification/iith_sig_src.sv
// behavioural signal equipment driving the trigger pins
`timescale 1ns/1ps
`default_nettype none
module iith_sig_src
  import iith_pkg::*;
#(
  parameter int HOLD = TICK_CYC
) (
  input wire logic clk_i,  // board clock
  input wire logic rst_i,  // sync reset, high
  input wire logic [NUM_IN-1:0] want_i,  // level the bench asks for
  output logic [NUM_IN-1:0] trig_o  // pin levels
);
  int held_ff [NUM_IN];
  // a new level only once the old one stood a full hold span
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NUM_IN; i++) begin
      if (rst_i) begin
        trig_o[i] <= 1'h1;
        held_ff[i] <= HOLD;
      end else if (want_i[i] != trig_o[i] && held_ff[i] >= HOLD) begin
        trig_o[i] <= want_i[i];
        held_ff[i] <= 1;
      end else if (held_ff[i] < HOLD) begin
        held_ff[i] <= held_ff[i] + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_iith_hub.sv
// self-checking testbench for the interrupt input and timer hub
`timescale 1ns/1ps
`default_nettype none
module tb_iith_hub;
  import iith_pkg::*;
  localparam int HOLD = TICK_CYC;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  iith_bus_req_t req = '0;
  logic [NUM_IN-1:0] want = '1;
  logic [NUM_IN-1:0] trig;
  logic [31:0] rdat;
  logic ack;
  logic [NUM_IN-1:0] host_irq;
  logic [NUM_TMR-1:0] tmr_irq;
  logic [NUM_CHAIN-1:0] chain;
  logic [NUM_OUT-1:0] ext_out;
  logic [31:0] q;
  int failures = 0;
  int check_count = 0;
  // 125 MHz board clock
  always #4 clk_i = ~clk_i;
  iith_sig_src #(.HOLD(HOLD)) u_src (.clk_i(clk_i), .rst_i(rst_i), .want_i(want),
    .trig_o(trig));
  iith_hub dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .trig_i(trig), .host_irq_o(host_irq),
    .tmr_irq_o(tmr_irq), .chain_shared_interrupt_o(chain), .ext_out_o(ext_out));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold everything until ack is sampled, then one idle cycle
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    req <= '{adr: a, we: w, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 64);
    if (ack !== 1'h1) failures++;
    q = rdat;
    cyc <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'h1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(a, 1'h0, 32'h0);
  endtask
  // bounded wait for the next cycle with output line 2 high
  task automatic wait_pulse(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ext_out[2] !== 1'h1 && n < 1000);
  endtask
  task automatic t_reset();
    check(32'(host_irq), 32'h0);
    rd(OFS_MODE);
    check(q, 32'(MODE_RST));
    rd(OFS_ARM_SET);
    check(q, 32'h0);
    rd(OFS_EN_SET);
    check(q, 32'h0);
    rd(OFS_CHAIN_SEL);
    check(q, 32'(CHAIN_SEL_RST));
    rd(8'h40);
    check(q, 32'h0);
    $display("reset test done");
  endtask
  // every trigger mode on input 0, with one-microsecond pulses
  task automatic t_modes();
    logic idle;
    wr(OFS_ARM_SET, 32'h3);
    wr(OFS_EN_SET, 32'h3);
    wr(OFS_CHAIN_SEL, (32'(CHAIN_SEL_RST) & 32'hFFFFFFE0) | 32'(SRC_IN0));
    wr(OFS_OUT_SEL_LO, 32'(SRC_IN0) << SRC_W);
    for (int m = 0; m < 4; m++) begin
      idle = m[0];
      wr(OFS_MODE, 32'(m));
      want[0] <= idle;
      repeat (2 * HOLD + 8) @(posedge clk_i);
      wr(OFS_PEND_CLR, 32'h1);
      repeat (4) @(posedge clk_i);
      check(32'(host_irq), 32'h0);
      want[0] <= ~idle;
      repeat (8) @(posedge clk_i);
      check(32'(host_irq), 32'h1);
      check(32'(chain[0]), 32'(!idle));
      check(32'(ext_out[1]), 32'(!idle));
      wr(OFS_PEND_CLR, 32'h1);
      repeat (4) @(posedge clk_i);
      check(32'(host_irq), 32'(m >= 2));
      want[0] <= idle;
    end
    want[0] <= 1'h1;
    repeat (2 * HOLD + 8) @(posedge clk_i);
    wr(OFS_PEND_CLR, 32'h1);
    $display("trigger mode test done");
  endtask
  task automatic t_arm_en();
    wr(OFS_EN_CLR, 32'h1);
    wr(OFS_INJECT, 32'h1);
    repeat (4) @(posedge clk_i);
    check(32'(host_irq), 32'h0);
    rd(OFS_INJECT);
    check(q, 32'h1);
    wr(OFS_EN_SET, 32'h1);
    repeat (4) @(posedge clk_i);
    check(32'(host_irq), 32'h1);
    wr(OFS_ARM_CLR, 32'h1);
    wr(OFS_INJECT, 32'h1);
    repeat (4) @(posedge clk_i);
    check(32'(host_irq), 32'h0);
    rd(OFS_INJECT);
    check(q, 32'h0);
    wr(OFS_ARM_SET, 32'h800);
    wr(OFS_EN_SET, 32'h800);
    wr(OFS_INJECT, 32'h801);
    repeat (4) @(posedge clk_i);
    check(32'(host_irq), 32'h800);
    rd(OFS_ARM_SET);
    check(q, 32'h802);
    wr(OFS_PEND_CLR, 32'hFFF);
    $display("arm and enable test done");
  endtask
  // timer 7: one-shot of three ticks, then periodic of two
  task automatic t_timer();
    int n;
    wr(8'hF0, 32'h3);
    wr(8'hF8, 32'h8);
    n = 0;
    while (tmr_irq[7] !== 1'h1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(n >= 2 * HOLD - 4 && n <= 3 * HOLD + 8), 32'h1);
    rd(8'hF8);
    check(q, 32'h0);
    rd(8'hF4);
    check(q, 32'h3);
    wr(OFS_TMR_PEND, 32'h80);
    repeat (4) @(posedge clk_i);
    check(32'(tmr_irq), 32'h0);
    wr(OFS_OUT_SEL_LO, 32'(SRC_TMR0 + 5'h7) << (2 * SRC_W));
    wr(8'hF0, 32'h2);
    wr(8'hF8, 32'hC);
    wait_pulse(n);
    wait_pulse(n);
    check(32'(n), 32'(2 * HOLD));
    wr(8'hF8, 32'h4);
    rd(8'hF8);
    check(q, 32'h4);
    wr(8'hF4, 32'h5);
    rd(8'hF0);
    check(q, 32'h5);
    rd(8'hF4);
    check(q, 32'h2);
    wr(OFS_TMR_PEND, 32'hFF);
    $display("timer test done");
  endtask
  task automatic t_pulse();
    wr(OFS_OUT_SEL_LO, 32'h0);
    wr(OFS_PULSE, 32'hFFF);
    repeat (3) @(posedge clk_i);
    check(32'(ext_out), 32'hFFF);
    wr(OFS_PULSE, 32'h5A5);
    repeat (3) @(posedge clk_i);
    check(32'(ext_out), 32'h5A5);
    $display("pulse output test done");
  endtask
  // watchdog: tests need under ten thousand cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_reset();
    t_modes();
    t_arm_en();
    t_timer();
    t_pulse();
    wrap_up();
  end
endmodule
`default_nettype wire
